//--- hdl/spi_clock_phase_control.sv
// Serial master clock control: registers, source selection, generator and phase-aware shifter
//
// Function
// - Bit 4 picks generator source: one slow 2MHz, zero main clock; resets zero.
// - Zero reload value forces the main clock, ignoring the source select bit.
// - Bit 2 sets clock idle level: one idles high, zero idles low; resets zero.
// - Receive phase one, the reset value: sample input on second and even edges.
// - Receive phase zero: sample input on first and odd edges.
// - Receive sampling edge depends only on receive phase, not polarity.
// - Transmit phase one: launch each output bit on the first edge of its period.
// - Transmit phase zero, the reset value: output bit present before first edge.
// - Launch edge depends only on transmit phase, not polarity.
// - Generator register holds a six-bit reload value, read/write, resetting to two.
`timescale 1ns/1ps
`include "spi_clk_ctrl_consts.svh"

module spi_clock_phase_control #(
  parameter int          PW        = `PRELOAD_WIDTH,
  parameter logic [7:0]  SLOW_HALF = `SLOW_HALF_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        slowSrcClk,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  output logic             serial_clock_pin,
  output logic             serial_data_out,
  input  wire logic        serial_data_in,
  output logic             chipSelect_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset synchronisers for both domains

  logic rstMeta_reg;
  logic rstSyncN_reg;
  logic lrstMeta_reg;
  logic lrstSyncN_reg;

  // Release the main-domain reset through two flip-flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_reg  <= 1'b0;
      rstSyncN_reg <= 1'b0;
    end else begin
      rstMeta_reg  <= 1'b1;
      rstSyncN_reg <= rstMeta_reg;
    end
  end

  // Release the slow-source-domain reset through two flip-flops
  always_ff @(posedge slowSrcClk or negedge reset_n) begin
    if (!reset_n) begin
      lrstMeta_reg  <= 1'b0;
      lrstSyncN_reg <= 1'b0;
    end else begin
      lrstMeta_reg  <= 1'b1;
      lrstSyncN_reg <= lrstMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slow source domain: divide the link clock into a 2MHz toggle

  logic [7:0] slowCnt_reg;
  logic [7:0] slowCnt_next;
  logic       slowTog_reg;
  logic       slowTog_next;

  // Free-running half-period counter; the toggle is the only signal leaving this domain
  always_comb begin
    slowCnt_next = slowCnt_reg + 8'h01;
    slowTog_next = slowTog_reg;
    if (slowCnt_reg == SLOW_HALF - 8'h01) begin
      slowCnt_next = 8'h00;
      slowTog_next = ~slowTog_reg;
    end
  end

  // Slow domain registers
  always_ff @(posedge slowSrcClk or negedge lrstSyncN_reg) begin
    if (!lrstSyncN_reg) begin
      slowCnt_reg <= 8'h00;
      slowTog_reg <= 1'b0;
    end else begin
      slowCnt_reg <= slowCnt_next;
      slowTog_reg <= slowTog_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Crossings into the main domain

  logic togMeta_reg;
  logic togSync_reg;
  logic togLast_reg;
  logic misoMeta_reg;
  logic misoSync_reg;
  logic slowTick;

  // Toggle and data pin each pass two flops; only the second flop feeds logic
  always_ff @(posedge mclk or negedge rstSyncN_reg) begin
    if (!rstSyncN_reg) begin
      togMeta_reg  <= 1'b0;
      togSync_reg  <= 1'b0;
      togLast_reg  <= 1'b0;
      misoMeta_reg <= 1'b0;
      misoSync_reg <= 1'b0;
    end else begin
      togMeta_reg  <= slowTog_reg;
      togSync_reg  <= togMeta_reg;
      togLast_reg  <= togSync_reg;
      misoMeta_reg <= serial_data_in;
      misoSync_reg <= misoMeta_reg;
    end
  end

  // One main-clock tick per slow source period: rising toggles only, so the rate is not doubled
  assign slowTick = togSync_reg & ~togLast_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  spi_clk_ctrl_pkg::clock_ctrl_t ctrl_reg;
  spi_clk_ctrl_pkg::clock_ctrl_t ctrl_next;
  logic [PW-1:0]                 preload_reg;
  logic [PW-1:0]                 preload_next;
  logic [31:0]                   rdData_reg;
  logic [31:0]                   rdData_next;
  logic                          startReq;
  logic [7:0]                    txByte;
  logic [7:0]                    rxByte_reg;
  logic                          busy;

  // Pack the control fields at their bit positions; reserved bits stay zero
  function automatic logic [31:0] ctrlWord(input spi_clk_ctrl_pkg::clock_ctrl_t c);
    logic [31:0] w;
    w                          = 32'h0000_0000;
    w[`BIT_SOURCE_SELECT]      = c.clockSourceSelect;
    w[`BIT_POLARITY]           = c.polarity;
    w[`BIT_RECEIVE_PHASE]      = c.receiveSamplePhase;
    w[`BIT_TRANSMIT_PHASE]     = c.transmitLaunchPhase;
    return w;
  endfunction

  // Writes take only defined bits; a start command is a one-cycle request
  always_comb begin
    ctrl_next    = ctrl_reg;
    preload_next = preload_reg;
    startReq     = 1'b0;
    txByte       = regWrData[`TX_BYTE_LSB +: 8];
    if (regWrite) begin
      unique case (regAddr)
        `OFS_CLOCK_CONTROL: begin
          ctrl_next.clockSourceSelect   = regWrData[`BIT_SOURCE_SELECT];
          ctrl_next.polarity            = regWrData[`BIT_POLARITY];
          ctrl_next.receiveSamplePhase  = regWrData[`BIT_RECEIVE_PHASE];
          ctrl_next.transmitLaunchPhase = regWrData[`BIT_TRANSMIT_PHASE];
        end
        `OFS_CLOCK_GENERATOR: begin
          preload_next = regWrData[PW-1:0];
        end
        `OFS_COMMAND: begin
          startReq = regWrData[`BIT_START];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data appears in the cycle after the strobe only; unmapped reads return zero
  always_comb begin
    rdData_next = 32'h0000_0000;
    if (regRead) begin
      unique case (regAddr)
        `OFS_CLOCK_CONTROL:   rdData_next = ctrlWord(ctrl_reg);
        `OFS_CLOCK_GENERATOR: rdData_next = {{(32-PW){1'b0}}, preload_reg};
        `OFS_STATUS: begin
          rdData_next[`BIT_BUSY]        = busy;
          rdData_next[`BIT_CLOCK_LEVEL] = serial_clock_pin;
        end
        `OFS_RECEIVE:         rdData_next = {24'h00_0000, rxByte_reg};
        default:              rdData_next = 32'h0000_0000;
      endcase
    end
  end

  // Register file state
  always_ff @(posedge mclk or negedge rstSyncN_reg) begin
    if (!rstSyncN_reg) begin
      ctrl_reg.clockSourceSelect   <= `RESET_SOURCE_SELECT;
      ctrl_reg.polarity            <= `RESET_POLARITY;
      ctrl_reg.receiveSamplePhase  <= `RESET_RECEIVE_PHASE;
      ctrl_reg.transmitLaunchPhase <= `RESET_TRANSMIT_PHASE;
      preload_reg                  <= `PRELOAD_RESET;
      rdData_reg                   <= 32'h0000_0000;
    end else begin
      ctrl_reg                     <= ctrl_next;
      preload_reg                  <= preload_next;
      rdData_reg                   <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock generator

  logic edgePulse;

  // Source choice travels with the preload; the generator applies the zero-preload override
  spi_clock_generator #(
    .PW        (PW)
  ) u_gen (
    .mclk      (mclk),
    .rstN      (rstSyncN_reg),
    .run       (busy),
    .slowTick  (slowTick),
    .useSlow   (ctrl_reg.clockSourceSelect),
    .preload   (preload_reg),
    .edgePulse (edgePulse)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Byte transfer sequencer

  spi_clk_ctrl_pkg::xfer_state_t state_reg;
  spi_clk_ctrl_pkg::xfer_state_t state_next;
  logic [4:0] edgeCnt_reg;
  logic [4:0] edgeCnt_next;
  logic [7:0] txShift_reg;
  logic [7:0] txShift_next;
  logic [7:0] rxShift_reg;
  logic [7:0] rxShift_next;
  logic [7:0] rxByte_next;
  logic       sclk_reg;
  logic       sclk_next;
  logic       mosi_reg;
  logic       mosi_next;
  logic       cs_n_reg;
  logic       cs_n_next;
  logic       oddEdge;
  logic       sampleNow;
  logic       launchNow;

  // Edge count zero is the first edge, so even counts are odd-numbered edges
  assign oddEdge = ~edgeCnt_reg[0];

  // Sampling follows the receive phase alone; polarity never enters here
  assign sampleNow = ctrl_reg.receiveSamplePhase ? ~oddEdge : oddEdge;

  // Launch follows the transmit phase alone; phase zero shifts on even edges after the first bit, except the last (sixteenth) edge
  assign launchNow = ctrl_reg.transmitLaunchPhase ? oddEdge
                   : (~oddEdge && (edgeCnt_reg != `EDGES_PER_BYTE - 5'h01));

  assign busy = (state_reg == spi_clk_ctrl_pkg::ST_RUN);

  // Sequencer next state; the slave side captures on the opposite edge class to launch
  always_comb begin
    state_next   = state_reg;
    edgeCnt_next = edgeCnt_reg;
    txShift_next = txShift_reg;
    rxShift_next = rxShift_reg;
    rxByte_next  = rxByte_reg;
    sclk_next    = sclk_reg;
    mosi_next    = mosi_reg;
    cs_n_next    = cs_n_reg;
    unique case (state_reg)
      spi_clk_ctrl_pkg::ST_IDLE: begin
        sclk_next = ctrl_reg.polarity;
        if (startReq) begin
          state_next   = spi_clk_ctrl_pkg::ST_RUN;
          edgeCnt_next = 5'h00;
          cs_n_next    = 1'b0;
          if (ctrl_reg.transmitLaunchPhase) begin
            txShift_next = txByte;
          end else begin
            mosi_next    = txByte[7];
            txShift_next = {txByte[6:0], 1'b0};
          end
        end
      end
      spi_clk_ctrl_pkg::ST_RUN: begin
        if (edgePulse) begin
          sclk_next    = ~sclk_reg;
          edgeCnt_next = edgeCnt_reg + 5'h01;
          if (launchNow) begin
            mosi_next    = txShift_reg[7];
            txShift_next = {txShift_reg[6:0], 1'b0};
          end
          if (sampleNow) begin
            rxShift_next = {rxShift_reg[6:0], misoSync_reg};
          end
          if (edgeCnt_reg == `EDGES_PER_BYTE - 5'h01) begin
            state_next = spi_clk_ctrl_pkg::ST_DONE;
          end
        end
      end
      spi_clk_ctrl_pkg::ST_DONE: begin
        // Last edge leaves the clock at its idle level again
        rxByte_next = rxShift_reg;
        cs_n_next   = 1'b1;
        state_next  = spi_clk_ctrl_pkg::ST_IDLE;
      end
      default: begin
        state_next = spi_clk_ctrl_pkg::ST_IDLE;
        cs_n_next  = 1'b1;
      end
    endcase
  end

  // Sequencer and pin registers; every serial pin output comes straight from here
  always_ff @(posedge mclk or negedge rstSyncN_reg) begin
    if (!rstSyncN_reg) begin
      state_reg   <= spi_clk_ctrl_pkg::ST_IDLE;
      edgeCnt_reg <= 5'h00;
      txShift_reg <= 8'h00;
      rxShift_reg <= 8'h00;
      rxByte_reg  <= 8'h00;
      sclk_reg    <= `RESET_POLARITY;
      mosi_reg    <= 1'b0;
      cs_n_reg    <= 1'b1;
    end else begin
      state_reg   <= state_next;
      edgeCnt_reg <= edgeCnt_next;
      txShift_reg <= txShift_next;
      rxShift_reg <= rxShift_next;
      rxByte_reg  <= rxByte_next;
      sclk_reg    <= sclk_next;
      mosi_reg    <= mosi_next;
      cs_n_reg    <= cs_n_next;
    end
  end

  assign serial_clock_pin = sclk_reg;
  assign serial_data_out  = mosi_reg;
  assign chipSelect_n     = cs_n_reg;

endmodule

//--- hdl/spi_clk_ctrl_consts.svh
// Register offsets, field positions, reset values and counts of the serial clock control block
`ifndef SPI_CLK_CTRL_CONSTS_SVH
`define SPI_CLK_CTRL_CONSTS_SVH

// Byte offsets of the registers
`define OFS_CLOCK_CONTROL    8'h14
`define OFS_CLOCK_GENERATOR  8'h18
`define OFS_STATUS           8'h1C
`define OFS_COMMAND          8'h20
`define OFS_RECEIVE          8'h24

// Clock control fields
`define BIT_TRANSMIT_PHASE   0
`define BIT_RECEIVE_PHASE    1
`define BIT_POLARITY         2
`define BIT_SOURCE_SELECT    4

// Clock generator fields
`define PRELOAD_WIDTH        6
`define PRELOAD_RESET        6'h02

// Status and command fields
`define BIT_BUSY             0
`define BIT_CLOCK_LEVEL      1
`define BIT_START            0
`define TX_BYTE_LSB          8

// Control reset values: receive phase set, all else clear
`define RESET_SOURCE_SELECT  1'h0
`define RESET_POLARITY       1'h0
`define RESET_RECEIVE_PHASE  1'h1
`define RESET_TRANSMIT_PHASE 1'h0

// Serial clock edges in one byte, and link clock cycles per slow-source half period
`define EDGES_PER_BYTE       5'h10
`define SLOW_HALF_CYCLES     8'h08

`endif

//--- hdl/spi_clk_ctrl_pkg.sv
// Types shared by the serial clock control block
package spi_clk_ctrl_pkg;

  // Clock control register contents
  typedef struct packed {
    logic clockSourceSelect;
    logic polarity;
    logic receiveSamplePhase;
    logic transmitLaunchPhase;
  } clock_ctrl_t;

  // Byte transfer sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } xfer_state_t;

endpackage

//--- hdl/spi_clock_generator.sv
// Programmable serial clock generator: reload counter that emits one pulse per clock edge
`timescale 1ns/1ps
`include "spi_clk_ctrl_consts.svh"

module spi_clock_generator #(
  parameter int PW = `PRELOAD_WIDTH
) (
  input  wire logic          mclk,
  input  wire logic          rstN,
  input  wire logic          run,
  input  wire logic          slowTick,
  input  wire logic          useSlow,
  input  wire logic [PW-1:0] preload,
  output logic               edgePulse
);

  logic [PW-1:0] count_reg;
  logic [PW-1:0] count_next;
  logic          edge_reg;
  logic          edge_next;
  logic          srcTick;

  // A zero preload forces the main clock regardless of the select bit
  assign srcTick = (useSlow && (preload != '0)) ? slowTick : 1'b1;

  // Count source ticks down; on expiry reload and emit an edge
  always_comb begin
    count_next = count_reg;
    edge_next  = 1'b0;
    if (!run) begin
      count_next = preload;
    end else if (srcTick) begin
      if (count_reg == '0) begin
        count_next = preload;
        edge_next  = 1'b1;
      end else begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  // Generator state
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      count_reg <= `PRELOAD_RESET;
      edge_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      edge_reg  <= edge_next;
    end
  end

  assign edgePulse = edge_reg;

endmodule

//--- verif/spi_clock_phase_control_sva.sv
// Port-level checker of register reads and serial clock timing
`timescale 1ns/1ps
`include "spi_clk_ctrl_consts.svh"

module spi_clock_phase_control_sva #(
  parameter int         PW        = `PRELOAD_WIDTH,
  parameter logic [7:0] SLOW_HALF = `SLOW_HALF_CYCLES
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  input wire logic        serial_clock_pin,
  input wire logic        serial_data_out,
  input wire logic        chipSelect_n
);
  logic          pol, rph, tph, src, fast, wrCtrl;
  logic [PW-1:0] pre;
  logic [7:0]    gap, edges, quiet;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////
  // Shadow of the control fields, the reference for reads and idle level
  assign wrCtrl = regWrite && regAddr == `OFS_CLOCK_CONTROL;
  assign fast   = !src || pre == '0;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {src, pol, rph, tph} <= 4'h2;
      pre <= `PRELOAD_RESET;
    end else begin
      if (wrCtrl) {src, pol, rph, tph} <= {regWrData[4], regWrData[2:0]};
      if (regWrite && regAddr == `OFS_CLOCK_GENERATOR) pre <= regWrData[PW-1:0];
    end
  end

  // Gap between clock changes, edges in this frame, idle cycles; gap and idle count saturate to avoid wrap
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap   <= 8'h00;
      edges <= 8'h00;
      quiet <= 8'h00;
    end else begin
      gap   <= $changed(serial_clock_pin) ? 8'h01 : gap + {7'h00, gap != 8'hFF};
      edges <= chipSelect_n ? 8'h00 : edges + {7'h00, $changed(serial_clock_pin)};
      quiet <= (!chipSelect_n || wrCtrl) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
    end
  end

  ////////////////////////////////////////
  property p_read_ctrl;
    $past(regRead) && $past(regAddr) == `OFS_CLOCK_CONTROL
      |-> regRdData == {27'h0, src, 1'h0, pol, rph, tph};
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");
  property p_read_gen;
    $past(regRead) && $past(regAddr) == `OFS_CLOCK_GENERATOR
      |-> regRdData == {{(32-PW){1'h0}}, pre};
  endproperty
  a_read_gen: assert property (p_read_gen) else $error("generator read wrong");
  property p_read_none;
    !$past(regRead) || !($past(regAddr) inside {`OFS_CLOCK_CONTROL, `OFS_CLOCK_GENERATOR,
      `OFS_STATUS, `OFS_COMMAND, `OFS_RECEIVE}) |-> regRdData == 32'h0;
  endproperty
  a_read_none: assert property (p_read_none) else $error("stray read data");
  property p_launch;
    !chipSelect_n && !$past(chipSelect_n) && $changed(serial_data_out)
      |-> $changed(serial_clock_pin) && serial_clock_pin == (pol ^ tph);
  endproperty
  a_launch: assert property (p_launch) else $error("data launched on wrong edge");
  property p_rate;
    $changed(serial_clock_pin) && !chipSelect_n && edges != 8'h00 && fast
      |-> gap == {2'h0, pre} + 8'h01;
  endproperty
  a_rate: assert property (p_rate) else $error("main source edge spacing wrong");
  property p_slow;
    $changed(serial_clock_pin) && !chipSelect_n && edges != 8'h00 && !fast
      |-> gap > {2'h0, pre} + 8'h01;
  endproperty
  a_slow: assert property (p_slow) else $error("slow source not used");
  property p_count;
    $rose(chipSelect_n) |-> edges == 8'h10;
  endproperty
  a_count: assert property (p_count) else $error("frame edge count wrong");
  property p_idle;
    chipSelect_n && quiet > 8'h04 |-> serial_clock_pin == pol;
  endproperty
  a_idle: assert property (p_idle) else $error("idle clock level wrong");

  c_frame: cover property ($rose(chipSelect_n) && edges == 8'h10);
  c_slow:  cover property ($changed(serial_clock_pin) && !fast && edges > 8'h01);
  c_high:  cover property (pol && $fell(chipSelect_n));
endmodule

bind spi_clock_phase_control spi_clock_phase_control_sva #(.PW(PW), .SLOW_HALF(SLOW_HALF)) u_sva (
  .mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .serial_clock_pin(serial_clock_pin), .serial_data_out(serial_data_out),
  .chipSelect_n(chipSelect_n));

//--- verif/spi_slave_model.sv
// Behavioural serial slave answering one byte per frame in all four clock formats
`timescale 1ns/1ps

module spi_slave_model (
  input  wire logic       serial_clock_pin,
  input  wire logic       chipSelect_n,
  input  wire logic       serial_data_out,
  input  wire logic       txPhase,
  input  wire logic       rxPhase,
  input  wire logic [7:0] replyByte,
  output logic            serial_data_in,
  output logic [7:0]      gotByte
);
  int         edgeNo;
  logic [7:0] shiftOut;

  initial serial_data_in = 1'h0;
  ////////////////////////////////////////
  // Frame start: with receive phase zero the first bit is valid before any edge
  always @(negedge chipSelect_n) begin
    edgeNo = 0;
    shiftOut = replyByte;
    serial_data_in = ~replyByte[7];
    if (!rxPhase) begin
      serial_data_in = shiftOut[7];
      shiftOut = {shiftOut[6:0], 1'h0};
    end
  end
  // Line is not held once deselected, so it shows the inverse of the last bit
  always @(posedge chipSelect_n) serial_data_in = ~serial_data_in;
  // Capture on the edges the transmit phase names, launch ahead of the master's sampling edge
  always @(serial_clock_pin) begin
    if (!chipSelect_n) begin
      edgeNo++;
      if (edgeNo[0] != txPhase) gotByte = {gotByte[6:0], serial_data_out};
      if (edgeNo[0] == rxPhase) begin
        serial_data_in = shiftOut[7];
        shiftOut = {shiftOut[6:0], 1'h0};
      end
    end
  end
endmodule

//--- verif/tb_top.sv
// Bench: register access, all clock formats in both polarities, source selection timing
`timescale 1ns/1ps
`include "spi_clk_ctrl_consts.svh"

module tb_top;
  logic        mclk, reset_n, slowSrcClk, regWrite, regRead, serial_data_in;
  logic        serial_clock_pin, serial_data_out, chipSelect_n, txPhase, rxPhase;
  logic [7:0]  regAddr, replyByte, gotByte;
  logic [31:0] regWrData, regRdData, rdVal;
  int          errors, checks_done, tog;
  time         tA, tB;

  spi_clock_phase_control #(.SLOW_HALF(8'h01)) DUT (
    .mclk(mclk), .reset_n(reset_n), .slowSrcClk(slowSrcClk), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .serial_clock_pin(serial_clock_pin), .serial_data_out(serial_data_out),
    .serial_data_in(serial_data_in), .chipSelect_n(chipSelect_n));
  spi_slave_model slave (
    .serial_clock_pin(serial_clock_pin), .chipSelect_n(chipSelect_n),
    .serial_data_out(serial_data_out), .txPhase(txPhase), .rxPhase(rxPhase),
    .replyByte(replyByte), .serial_data_in(serial_data_in), .gotByte(gotByte));

  ////////////////////////////////////////
  // Main clock and a free-running slow source clock of unrelated phase
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    slowSrcClk = 1'h0;
    #1.3;
    forever #32 slowSrcClk = ~slowSrcClk;
  end
  // Count clock edges inside a frame and stamp the second and third
  always @(serial_clock_pin) begin
    if (!chipSelect_n) begin
      tog++;
      if (tog == 2) tA = $time;
      if (tog == 3) tB = $time;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge mclk);
    regWrite <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge mclk);
    regRead <= 1'h0;
    @(negedge mclk);
    rdVal = regRdData;
  endtask
  // One byte frame; polls busy under a bound since a hang must not stall the run
  task automatic xfer(input logic [31:0] ctrl, input logic [5:0] pre, input logic [7:0] tx, rep);
    int n;
    // Settings change only while idle, never inside a frame
    wr(`OFS_CLOCK_CONTROL, ctrl);
    wr(`OFS_CLOCK_GENERATOR, {26'h0, pre});
    txPhase = ctrl[0];
    rxPhase = ctrl[1];
    replyByte = rep;
    tog = 0;
    wr(`OFS_COMMAND, {16'h0, tx, 8'h01});
    n = 0;
    do begin
      rd(`OFS_STATUS);
      n++;
    end while (rdVal[0] && n < 2000);
    chk(32'(n < 2000), 32'h1, "transfer hung");
    chk(32'(tog), 32'h10, "edge count");
  endtask
  task automatic summarize();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Watchdog well beyond the expected run of under ten microseconds
  initial begin
    #200000;
    errors++;
    summarize();
  end
  initial begin
    {regAddr, regWrData, regWrite, regRead, txPhase, rxPhase, replyByte} = '0;
    reset_n = 1'h0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (3) @(posedge mclk);
    rd(`OFS_CLOCK_CONTROL);
    chk(rdVal, 32'h2, "control reset");
    rd(`OFS_CLOCK_GENERATOR);
    chk(rdVal, 32'h2, "generator reset");
    chk(32'(serial_clock_pin), 32'h0, "idle low");
    wr(`OFS_CLOCK_CONTROL, 32'hFFFFFFFF);
    wr(`OFS_CLOCK_GENERATOR, 32'hFFFFFFFF);
    rd(`OFS_CLOCK_CONTROL);
    chk(rdVal, 32'h17, "control reserved bits");
    rd(`OFS_CLOCK_GENERATOR);
    chk(rdVal, 32'h3F, "generator width");
    chk(32'(serial_clock_pin), 32'h1, "idle high");
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30);
    chk(rdVal, 32'h0, "unmapped read");
    // Every phase pair in both polarities, main source, reload three
    for (int i = 0; i < 8; i++) begin
      xfer(32'(i), 6'h03, 8'hA5 ^ 8'(i * 17), 8'h3C ^ 8'(i * 9));
      chk(32'(gotByte), 32'(8'hA5 ^ 8'(i * 17)), "slave byte");
      rd(`OFS_RECEIVE);
      chk(rdVal, 32'(8'h3C ^ 8'(i * 9)), "master byte");
      chk(32'(tB - tA), 32'h14, "main rate");
      chk(32'(serial_clock_pin), 32'(i / 4), "idle level");
      // Status shows not busy and the clock resting at the polarity level
      rd(`OFS_STATUS);
      chk(rdVal, 32'((i / 4) * 2), "status idle level");
    end
    // Slow source: one tick per 128 ns, edge every second tick
    xfer(32'h12, 6'h01, 8'h5A, 8'hC3);
    chk(32'(tB - tA >= 251 && tB - tA <= 261), 32'h1, "slow rate");
    chk(32'(gotByte), 32'h5A, "slow slave byte");
    rd(`OFS_RECEIVE);
    chk(rdVal, 32'hC3, "slow master byte");
    // Zero reload overrides the slow select
    xfer(32'h12, 6'h00, 8'h81, 8'h18);
    chk(32'(tB - tA), 32'h5, "forced main clock");
    summarize();
  end
endmodule
